//--- rtl/sfbl_pkg.sv
// shared constants of the serial firmware boot loader
package sfbl_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int BAUD_RATE = 115200;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
	localparam int STRAP_SETUP_NS = 5000;
	localparam int STRAP_SETUP_CYCLES = (STRAP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_MAX_MS = 200;
	localparam int STARTUP_TYP_MS = 135;
	localparam int STARTUP_TYP_CYCLES = STARTUP_TYP_MS * (CLK_HZ / 1000);
	localparam int INTERBYTE_MAX_MS = 20;
	localparam int INTERBYTE_CYCLES = INTERBYTE_MAX_MS * (CLK_HZ / 1000);
	localparam int ACK_MAX_MS = 12;
	localparam int ACK_TYP_US = 3600;
	localparam int ACK_TYP_CYCLES = ACK_TYP_US * (CLK_HZ / 1000000);
	localparam int STRAP_HOLD_US = 36;
	localparam int STRAP_HOLD_CYCLES = STRAP_HOLD_US * (CLK_HZ / 1000000);
	localparam int CNT_W = 24;
	// ----------------------------------------
	// link values
	// ----------------------------------------
	localparam logic [7:0] ACK_BYTE = 8'h06;
	localparam logic [1:0] BAUD_SEL_115200 = 2'h0;
	localparam logic STRAP_SERIAL = 1'h1;
endpackage

//--- rtl/sfbl_if.sv
// link interface between host and boot loader
`timescale 1ns/1ps
interface sfbl_if;
	logic reset_n_input;
	logic boot_select_strap;
	logic host_to_dev;
	logic dev_to_host;
	modport device (input reset_n_input, input boot_select_strap, input host_to_dev, output dev_to_host);
	modport host (output reset_n_input, output boot_select_strap, output host_to_dev, input dev_to_host);
endinterface

//--- rtl/sfbl_device.sv
// device end: boot loader receiving firmware over the serial link
`timescale 1ns/1ps
module sfbl_device
	import sfbl_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_TYP_CYCLES,
	parameter int ACK_DELAY_CYCLES = ACK_TYP_CYCLES,
	parameter int TIMEOUT_CYCLES = INTERBYTE_CYCLES,
	parameter int IMAGE_BYTES = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// link
	sfbl_if.device link,
	// straps
	input wire logic i_baud_strap_low,
	input wire logic i_baud_strap_high,
	// memory fetch side
	input wire logic i_mem_done,
	output logic o_mem_fetch,
	// firmware write port
	output logic o_fw_we,
	output logic [15:0] o_fw_addr,
	output logic [7:0] o_fw_data,
	// status
	output logic o_loader_ready,
	output logic o_fw_loaded,
	output logic o_baud_bad,
	output logic o_timeout
);
	typedef enum logic [5:0] {
		ST_BOOT = 6'b00_0001,
		ST_RECV = 6'b00_0010,
		ST_WAIT = 6'b00_0100,
		ST_SEND = 6'b00_1000,
		ST_FETCH = 6'b01_0000,
		ST_RUN = 6'b10_0000
	} sfbl_dev_state_type;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] sync1_q, sync2_q;
	logic rxd, rst_n_pin, strap, baud_ok;
	always_ff @(posedge i_core_clk) begin
		// baud straps are pins too, so both take the same two stages
		sync1_q <= {link.reset_n_input, link.boot_select_strap, link.host_to_dev, i_baud_strap_high, i_baud_strap_low};
		sync2_q <= sync1_q;
	end
	assign rst_n_pin = sync2_q[4];
	assign strap = sync2_q[3];
	assign rxd = sync2_q[2];

	// ----------------------------------------
	// control state
	// ----------------------------------------
	sfbl_dev_state_type st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] gap_q, gap_d;
	logic [9:0] rx_sh_q, rx_sh_d;
	logic [3:0] rx_bit_q, rx_bit_d;
	logic [8:0] rx_div_q, rx_div_d;
	logic rx_busy_q, rx_busy_d;
	logic [9:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_bit_q, tx_bit_d;
	logic [8:0] tx_div_q, tx_div_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] data_q, data_d;
	logic we_q, we_d;
	logic sel_q, sel_d;
	logic rst_n_prev_q, timeout_q, timeout_d;
	logic [1:0] baud_q, baud_d;
	logic in_reset;

	assign in_reset = i_rst || !rst_n_pin;
	assign baud_ok = (baud_q == BAUD_SEL_115200);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		gap_d = gap_q;
		rx_sh_d = rx_sh_q;
		rx_bit_d = rx_bit_q;
		rx_div_d = rx_div_q;
		rx_busy_d = rx_busy_q;
		tx_sh_d = tx_sh_q;
		tx_bit_d = tx_bit_q;
		tx_div_d = tx_div_q;
		addr_d = addr_q;
		data_d = data_q;
		we_d = 1'b0;
		sel_d = sel_q;
		baud_d = baud_q;
		timeout_d = timeout_q;
		// reset release: catch straps after the pin goes high
		if (rst_n_prev_q == 1'b0 && rst_n_pin) begin
			sel_d = strap;
			baud_d = sync2_q[1:0];
		end
		case (st_q)
			ST_BOOT: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= CNT_W'(STARTUP_CYCLES - 1)) begin
					cnt_d = '0;
					gap_d = '0;
					addr_d = '0;
					st_d = (sel_q == STRAP_SERIAL) ? ST_RECV : ST_FETCH;
				end
			end
			ST_RECV: begin
				// receive 8N1 at 115200 only; any other baud strap setting receives nothing
				if (!rx_busy_q) begin
					gap_d = gap_q + 1'b1;
					if (addr_q != 16'h0000 && gap_q >= CNT_W'(TIMEOUT_CYCLES)) begin
						timeout_d = 1'b1;
						addr_d = '0;
						gap_d = '0;
					end
					if (!rxd && baud_ok) begin
						rx_busy_d = 1'b1;
						rx_div_d = 9'(BIT_CYCLES / 2);
						rx_bit_d = '0;
					end
				end else if (rx_div_q != 9'h000) begin
					rx_div_d = rx_div_q - 1'b1;
				end else begin
					rx_div_d = 9'(BIT_CYCLES - 1);
					rx_sh_d = {rxd, rx_sh_q[9:1]};
					rx_bit_d = rx_bit_q + 1'b1;
					if (rx_bit_q == 4'h0 && rxd) begin
						rx_busy_d = 1'b0;
					end else if (rx_bit_q == 4'h9) begin
						rx_busy_d = 1'b0;
						gap_d = '0;
						if (rxd) begin
							we_d = 1'b1;
							data_d = rx_sh_q[9:2];
							addr_d = addr_q + 1'b1;
							timeout_d = 1'b0;
							if (addr_q == 16'(IMAGE_BYTES - 1)) begin
								cnt_d = '0;
								st_d = ST_WAIT;
							end
						end
					end
				end
			end
			ST_WAIT: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= CNT_W'(ACK_DELAY_CYCLES - 1)) begin
					tx_sh_d = {1'b1, ACK_BYTE, 1'b0};
					tx_bit_d = '0;
					tx_div_d = 9'(BIT_CYCLES - 1);
					st_d = ST_SEND;
				end
			end
			ST_SEND: begin
				if (tx_div_q != 9'h000) begin
					tx_div_d = tx_div_q - 1'b1;
				end else begin
					tx_div_d = 9'(BIT_CYCLES - 1);
					tx_sh_d = {1'b1, tx_sh_q[9:1]};
					tx_bit_d = tx_bit_q + 1'b1;
					if (tx_bit_q == 4'h9) begin
						st_d = ST_RUN;
					end
				end
			end
			ST_FETCH: begin
				if (i_mem_done) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				st_d = ST_RUN;
			end
			default: begin
				st_d = ST_BOOT;
			end
		endcase
		data_d = we_d ? data_d : data_q;
		if (in_reset) begin
			st_d = ST_BOOT;
			cnt_d = '0;
			rx_busy_d = 1'b0;
			tx_sh_d = 10'h3ff;
			timeout_d = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_q <= ST_BOOT;
			cnt_q <= '0;
			gap_q <= '0;
			rx_sh_q <= '0;
			rx_bit_q <= '0;
			rx_div_q <= '0;
			rx_busy_q <= 1'b0;
			tx_sh_q <= 10'h3ff;
			tx_bit_q <= '0;
			tx_div_q <= '0;
			addr_q <= '0;
			data_q <= '0;
			we_q <= 1'b0;
			sel_q <= STRAP_SERIAL;
			baud_q <= BAUD_SEL_115200;
			rst_n_prev_q <= 1'b0;
			timeout_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			gap_q <= gap_d;
			rx_sh_q <= rx_sh_d;
			rx_bit_q <= rx_bit_d;
			rx_div_q <= rx_div_d;
			rx_busy_q <= rx_busy_d;
			tx_sh_q <= tx_sh_d;
			tx_bit_q <= tx_bit_d;
			tx_div_q <= tx_div_d;
			addr_q <= addr_d;
			data_q <= data_d;
			we_q <= we_d;
			sel_q <= sel_d;
			baud_q <= baud_d;
			rst_n_prev_q <= rst_n_pin;
			timeout_q <= timeout_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// two wires only, idle high
	assign link.dev_to_host = (st_q == ST_SEND) ? tx_sh_q[0] : 1'b1;
	assign o_mem_fetch = (st_q == ST_FETCH);
	assign o_fw_we = we_q;
	assign o_fw_addr = addr_q - 16'h0001;
	assign o_fw_data = data_q;
	assign o_loader_ready = (st_q == ST_RECV);
	assign o_fw_loaded = (st_q == ST_RUN);
	assign o_baud_bad = !baud_ok;
	assign o_timeout = timeout_q;
endmodule // sfbl_device

//--- rtl/sfbl_host.sv
// host end: drives strap and reset, uploads an image, awaits the ack
`timescale 1ns/1ps
module sfbl_host
	import sfbl_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// link
	sfbl_if.host link,
	// user side
	input wire logic i_start,
	input wire logic i_serial,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_last,
	output logic o_byte_ready,
	output logic o_ack_ok,
	output logic o_busy
);
	typedef enum logic [4:0] {
		HS_IDLE = 5'b0_0001,
		HS_SETUP = 5'b0_0010,
		HS_SEND = 5'b0_0100,
		HS_ACK = 5'b0_1000,
		HS_HOLD = 5'b1_0000
	} sfbl_host_state_type;

	// ----------------------------------------
	// control
	// ----------------------------------------
	sfbl_host_state_type st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [9:0] sh_q, sh_d;
	logic [3:0] bit_q, bit_d;
	logic last_q, last_d, strap_q, strap_d, rstn_q, rstn_d, ok_q, ok_d;
	logic [1:0] rx1_q;
	logic rx;
	assign rx = rx1_q[1];

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		bit_d = bit_q;
		last_d = last_q;
		strap_d = strap_q;
		rstn_d = rstn_q;
		ok_d = ok_q;
		case (st_q)
			HS_IDLE: begin
				if (i_start) begin
					strap_d = i_serial;
					cnt_d = '0;
					ok_d = 1'b0;
					st_d = HS_SETUP;
				end
			end
			HS_SETUP: begin
				// strap settles before reset falls
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(STRAP_SETUP_CYCLES)) begin
					rstn_d = 1'b0;
				end
				if (cnt_q == CNT_W'(2 * STRAP_SETUP_CYCLES)) begin
					rstn_d = 1'b1;
					cnt_d = '0;
					bit_d = 4'hf;
					st_d = strap_q ? HS_SEND : HS_IDLE;
				end
			end
			HS_SEND: begin
				// byte framing on the shared bit clock
				cnt_d = cnt_q + 1'b1;
				if (bit_q == 4'hf) begin
					if (i_byte_valid) begin
						sh_d = {1'b1, i_byte, 1'b0};
						last_d = i_last;
						bit_d = '0;
						cnt_d = '0;
					end
				end else if (cnt_q == CNT_W'(BIT_CYCLES - 1)) begin
					cnt_d = '0;
					sh_d = {1'b1, sh_q[9:1]};
					bit_d = (bit_q == 4'h9) ? 4'hf : bit_q + 1'b1;
					if (bit_q == 4'h9 && last_q) begin
						st_d = HS_ACK;
					end
				end
			end
			HS_ACK: begin
				if (!rx) begin
					cnt_d = '0;
					st_d = HS_HOLD;
				end
			end
			HS_HOLD: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= CNT_W'(STRAP_HOLD_CYCLES)) begin
					ok_d = 1'b1;
					st_d = HS_IDLE;
				end
			end
			default: begin
				st_d = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_q <= HS_IDLE;
			cnt_q <= '0;
			sh_q <= 10'h3ff;
			bit_q <= 4'hf;
			last_q <= 1'b0;
			strap_q <= STRAP_SERIAL;
			rstn_q <= 1'b1;
			ok_q <= 1'b0;
			rx1_q <= 2'b11;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			last_q <= last_d;
			strap_q <= strap_d;
			rstn_q <= rstn_d;
			ok_q <= ok_d;
			rx1_q <= {rx1_q[0], link.dev_to_host};
		end
	end

	assign link.reset_n_input = rstn_q;
	assign link.boot_select_strap = strap_q;
	assign link.host_to_dev = (st_q == HS_SEND && bit_q != 4'hf) ? sh_q[0] : 1'b1;
	assign o_byte_ready = (st_q == HS_SEND && bit_q == 4'hf);
	assign o_ack_ok = ok_q;
	assign o_busy = (st_q != HS_IDLE);
endmodule // sfbl_host

//--- bench/sfbl_chk.sv
// concurrent checks on the host to loader link
`timescale 1ns/1ps
module sfbl_chk
	import sfbl_pkg::*;
#(
	parameter int ACK_DELAY_CYCLES = ACK_TYP_CYCLES
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// link
	input wire logic reset_n_input,
	input wire logic boot_select_strap,
	input wire logic host_to_dev,
	input wire logic dev_to_host
);
	localparam int B = BIT_CYCLES;
	logic [23:0] d_run, h_run, s_age, a_age;
	function automatic logic [23:0] inc(input logic [23:0] v);
		return v + 24'(v != '1);
	endfunction
	// ----
	// run lengths, saturating so idle stretches never wrap
	// ----
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			{d_run, h_run, s_age, a_age} <= '1;
		end else begin
			d_run <= $changed(dev_to_host) ? 24'h1 : inc(d_run);
			h_run <= $changed(host_to_dev) ? 24'h1 : inc(h_run);
			s_age <= $changed(boot_select_strap) ? 24'h1 : inc(s_age);
			a_age <= $fell(dev_to_host) ? 24'h1 : inc(a_age);
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	a_boot_idle: assert property ((!reset_n_input) [*6] |-> dev_to_host)
		else $error("loader line busy in reset");
	a_ack_low: assert property ($rose(dev_to_host) |-> d_run inside {[2*B-3:2*B+3], [5*B-3:5*B+3]})
		else $error("ack low run wrong");
	a_ack_high: assert property ($fell(dev_to_host) |-> d_run > 10*B || d_run inside {[2*B-3:2*B+3]})
		else $error("ack high run wrong");
	a_ack_delay: assert property ($fell(dev_to_host) && d_run > 10*B
		|-> host_to_dev && h_run inside {[ACK_DELAY_CYCLES:ACK_DELAY_CYCLES+B+9]})
		else $error("ack start late or early");
	a_strap_hold: assert property ($changed(boot_select_strap) |-> a_age > STRAP_HOLD_CYCLES)
		else $error("strap moved too soon after ack");
	a_strap_setup: assert property ($fell(reset_n_input) |-> s_age >= STRAP_SETUP_CYCLES)
		else $error("strap setup too short");
	a_host_low: assert property ($rose(host_to_dev) && reset_n_input |-> h_run >= B-3 && h_run <= 9*B+3)
		else $error("host low run wrong");
	a_host_quiet: assert property (!reset_n_input |-> host_to_dev)
		else $error("host sends in reset");
endmodule // sfbl_chk

//--- bench/testbench.sv
// self-checking bench joining host and loader ends
`timescale 1ns/1ps
module testbench;
	import sfbl_pkg::*;
	// shortened counts keep the run short
	localparam int SU = 2000;
	localparam int AD = 500;
	localparam int TO = 4000;
	localparam int B = BIT_CYCLES;
	logic clk = 0, rst = 1, bl = 0, bh = 0, md = 0, st = 0, ser = 1, bv = 0, last = 0;
	logic [7:0] bt = 8'h00;
	logic mf, we, rdy, ld, bb, tmo, br, ak, bsy;
	logic [15:0] fa;
	logic [7:0] fd;
	logic [7:0] fw [2];
	int wr_n = 0;
	int error_cnt = 0;
	int total_checks = 0;
	sfbl_if lk();
	sfbl_device #(.STARTUP_CYCLES(SU), .ACK_DELAY_CYCLES(AD), .TIMEOUT_CYCLES(TO), .IMAGE_BYTES(2)) i_sfbl_device(
		.i_core_clk(clk), .i_rst(rst), .link(lk), .i_baud_strap_low(bl), .i_baud_strap_high(bh),
		.i_mem_done(md), .o_mem_fetch(mf), .o_fw_we(we), .o_fw_addr(fa), .o_fw_data(fd),
		.o_loader_ready(rdy), .o_fw_loaded(ld), .o_baud_bad(bb), .o_timeout(tmo));
	sfbl_host i_sfbl_host(.i_core_clk(clk), .i_rst(rst), .link(lk), .i_start(st), .i_serial(ser),
		.i_byte_valid(bv), .i_byte(bt), .i_last(last), .o_byte_ready(br), .o_ack_ok(ak), .o_busy(bsy));
	sfbl_chk #(.ACK_DELAY_CYCLES(AD)) i_sfbl_chk(.i_core_clk(clk), .i_rst(rst),
		.reset_n_input(lk.reset_n_input), .boot_select_strap(lk.boot_select_strap),
		.host_to_dev(lk.host_to_dev), .dev_to_host(lk.dev_to_host));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (we === 1'b1) begin
		fw[fa[0]] <= fd;
		wr_n <= wr_n + 1;
	end
	// ----
	// shared tasks
	// ----
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			error_cnt++;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic flag(input int k);
		return k == 0 ? rdy : k == 1 ? mf : k == 2 ? ld : ak;
	endfunction
	task automatic wait_flag(input int k, output int n);
		n = 0;
		while (flag(k) !== 1'b1 && n < 30000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic boot(input logic s);
		@(posedge clk);
		ser <= s;
		st <= 1;
		@(posedge clk);
		st <= 0;
	endtask
	task automatic send(input logic [7:0] v, input logic l);
		@(posedge clk);
		bv <= 1;
		bt <= v;
		last <= l;
		do @(posedge clk); while (br !== 1'b1);
		bv <= 0;
		last <= 0;
	endtask
	// decodes one frame off either wire, mid-bit sampling
	task automatic rx(input bit d, output logic [7:0] v, output int w);
		w = 0;
		while ((d ? lk.dev_to_host : lk.host_to_dev) !== 1'b0 && w < 30000) begin
			@(posedge clk);
			w++;
		end
		repeat (B / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (B) @(posedge clk);
			v[i] = d ? lk.dev_to_host : lk.host_to_dev;
		end
		repeat (B) @(posedge clk);
		chk("stop", d ? lk.dev_to_host : lk.host_to_dev, 1);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_mem();
		int n;
		boot(0);
		wait_flag(1, n);
		chk("fetch", mf, 1);
		chk("ready", rdy, 0);
		md <= 1;
		wait_flag(2, n);
		chk("loaded", ld, 1);
		chk("busy_mem", bsy, 0);
		md <= 0;
		$display("test mem_fetch done");
	endtask
	// a gap past the timeout, then a full image and its ack
	task automatic t_upload();
		int n;
		logic [7:0] v;
		boot(1);
		wait_flag(0, n);
		chk("ready_time", n >= SU && n <= SU + 2000, 1);
		chk("busy_up", bsy, 1);
		fork
			send(8'h5A, 0);
			rx(0, v, n);
		join
		chk("wire_byte", v, 8'h5A);
		repeat (TO + 2 * B) @(posedge clk);
		chk("timeout", tmo, 1);
		send(8'hA5, 0);
		send(8'h3C, 1);
		rx(1, v, n);
		chk("ack", v, ACK_BYTE);
		chk("ack_time", n >= 9 * B + AD && n <= 11 * B + AD + 20, 1);
		chk("addr0", fw[0], 8'hA5);
		chk("addr1", fw[1], 8'h3C);
		// the ack stop bit is still on the wire when rx returns
		wait_flag(2, n);
		chk("loaded", ld, 1);
		chk("tmo_clr", tmo, 0);
		wait_flag(3, n);
		chk("ack_ok", ak, 1);
		$display("test upload done");
	endtask
	task automatic t_baud();
		int n;
		for (int c = 1; c < 4; c++) begin
			// host waits for an ack that never comes, so restart both ends
			{bh, bl} <= 2'(c);
			rst <= 1;
			repeat (3) @(posedge clk);
			rst <= 0;
			boot(1);
			repeat (SU + 2000) @(posedge clk);
			n = wr_n;
			send(8'h77, 1);
			repeat (11 * B) @(posedge clk);
			chk("no_write", 24'(wr_n), 24'(n));
			chk("baud_bad", bb, 1);
		end
		{bh, bl} <= 2'h0;
		$display("test baud_straps done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		t_mem();
		t_upload();
		t_baud();
		give_verdict();
	end
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
endmodule // testbench
